// *** hdl/cipher_engine_ctrl.sv ***
// control sequencing of the block cipher engine with its register port
// assumes synchronous single-clock system bus, one-cycle strobes
//
// Overview of operation
// RQ1: software enables engine before any operation
// RQ2: config fields pick algorithm, mode, key
// RQ3: operation 0000 encrypts, 0001 decrypts
// RQ4: only lowest n key bits used
// RQ5: illegal config sets fault, refuses start
// RQ6: DES block 64 bits, AES 128
// RQ7: DES decrypt reads low 64 of second text
// RQ8: go starts, clears on done, done flag
// RQ9: free-text interrupt when enable bit 10 set
// RQ10: software reads go to tell sources
// RQ11: result readable in text register after done
// RQ12: more blocks need only text and go
// RQ13: software expands key before AES decrypt
// RQ14: engine self-expands key, go held throughout
// RQ15: no register changes while go set; the code still accepts register writes while busy and only holds go
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`include "cipher_engine_regs.svh"
module cipher_engine_ctrl
  import cipher_engine_pkg::*;
(
  input  wire logic         clk,        // 50 MHz system clock
  input  wire logic         reset,      // synchronous, active high
  input  wire logic [7:0]   addr,       // register byte address
  input  wire logic [31:0]  wdata,      // write data
  input  wire logic         wr,         // write strobe
  input  wire logic         rd,         // read strobe
  output logic      [31:0]  rdata,      // read data, cycle after rd
  input  wire logic [255:0] storedKey,  // key from key storage
  input  wire logic         keyStored,  // pulse: key storage programmed
  output logic              irq         // level interrupt
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0]  ctrl_q, ctrl_d;         // low control register
  logic [6:0]   cfg_q, cfg_d;           // configuration register
  logic [255:0] key_q, key_d;           // software key register
  logic [127:0] txt1_q, txt1_d;         // first text register
  logic [127:0] txt2_q, txt2_d;         // second text register
  logic [127:0] work_q, work_d;         // working block
  logic [127:0] chain_q, chain_d;       // chaining value
  logic [1:0]   flag_q, flag_d;         // sticky done, free
  logic [1:0]   mask_q, mask_d;         // interrupt mask
  logic         needExp_q, needExp_d;   // key expansion pending
  logic         dec_q, dec_d;           // running a decrypt
  logic [4:0]   cnt_q, cnt_d;           // round counter
  eng_state_type st_q, st_d;            // sequencer state
  logic [31:0]  rdata_d;                // read data next value
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic         ctrlWr, cfgWr, keyWr, t1Wr, t2Wr, goWr, start;
  logic         isAes, fault;
  logic [1:0]   cmode, klen;
  logic [3:0]   opsel;
  logic [15:0]  ctrlNow;                // control word, written value in its write cycle
  logic [255:0] keyMask, keyEff;
  logic [4:0]   rounds;
  logic [127:0] blkMask;
  assign ctrlWr = wr && addr == `OFS_CTRL_LOW;
  assign cfgWr  = wr && addr == `OFS_CONFIG;
  assign keyWr  = wr && addr[7:5] == 3'(`OFS_KEY_BASE >> 5);
  assign t1Wr   = wr && addr[7:4] == 4'(`OFS_TXT1_BASE >> 4);
  assign t2Wr   = wr && addr[7:4] == 4'(`OFS_TXT2_BASE >> 4);
  assign goWr   = ctrlWr && wdata[`BIT_GO];
  // go written with a new operation must act on that operation, not the old one
  assign ctrlNow = ctrlWr ? wdata[15:0] : ctrl_q;
  // RQ2: fields that select the run
  assign isAes  = cfg_q[`BIT_ALG];
  assign cmode  = cfg_q[2:1];
  assign klen   = cfg_q[5:4];
  assign opsel  = ctrlNow[3:0];
  // RQ5: illegal combinations
  always_comb begin
    fault = !ctrlNow[`BIT_ENABLE] || cmode[1] || klen == 2'b11
            || opsel > `OP_KEYEXP || (opsel == `OP_KEYEXP && !isAes);
  end
  // RQ4: key bits above the length are dropped
  always_comb begin
    case (klen)
      2'b00:   keyMask = isAes ? {{128{1'b0}}, {128{1'b1}}} : {{192{1'b0}}, {64{1'b1}}};
      2'b01:   keyMask = isAes ? {{64{1'b0}}, {192{1'b1}}} : {{128{1'b0}}, {128{1'b1}}};
      2'b10:   keyMask = isAes ? {256{1'b1}} : {{64{1'b0}}, {192{1'b1}}};
      default: keyMask = '0;
    endcase
    keyEff = (cfg_q[`BIT_KEYSRC] ? storedKey : key_q) & keyMask;
  end
  // RQ6: block width and round count per algorithm
  always_comb begin
    blkMask = isAes ? {128{1'b1}} : {{64{1'b0}}, {64{1'b1}}};
    case ({isAes, klen})
      3'b100:  rounds = `ROUNDS_AES128;
      3'b101:  rounds = `ROUNDS_AES192;
      3'b110:  rounds = `ROUNDS_AES256;
      default: rounds = `ROUNDS_DES;
    endcase
  end
  // round step: xor key then rotate within block, inverse for decrypt
  function automatic logic [127:0] stepFn(input logic [127:0] s, input logic [127:0] k,
                                          input logic aes, input logic dec);
    logic [127:0] r;
    r = '0;
    if (aes) begin
      r = dec ? ({s[0], s[127:1]} ^ k) : ({s[126:0], s[127]} ^ {k[126:0], k[127]});
    end else begin
      r[63:0] = dec ? ({s[0], s[63:1]} ^ k[63:0]) : ({s[62:0], s[63]} ^ {k[62:0], k[63]});
    end
    return r;
  endfunction
  assign start = goWr && st_q == IDLE && !ctrl_q[`BIT_GO] && !fault;
  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // next-state and datapath computation
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    work_d    = work_q;
    chain_d   = chain_q;
    dec_d     = dec_q;
    needExp_d = needExp_q;
    txt1_d    = txt1_q;
    txt2_d    = txt2_q;
    ctrl_d    = ctrl_q;
    cfg_d     = cfg_q;
    key_d     = key_q;
    flag_d    = flag_q;
    mask_d    = mask_q;
    // register writes, go kept while busy
    if (ctrlWr) begin
      ctrl_d = wdata[15:0];
      ctrl_d[`BIT_KEYPROG] = 1'b0;
      // RQ5: refused start leaves go clear
      ctrl_d[`BIT_GO] = ctrl_q[`BIT_GO] || start;
    end
    if (cfgWr) begin
      cfg_d = wdata[6:0];
      chain_d = '0;
      // RQ14: length or source change forces expansion
      if (wdata[5:4] != klen || wdata[`BIT_KEYSRC] != cfg_q[`BIT_KEYSRC]) begin
        needExp_d = 1'b1;
      end
    end
    if (keyStored || (ctrlWr && wdata[`BIT_KEYPROG])) begin
      needExp_d = 1'b1;
    end
    if (keyWr) begin
      key_d[addr[4:2]*32 +: 32] = wdata;
    end
    if (t1Wr) begin
      txt1_d[addr[3:2]*32 +: 32] = wdata;
    end
    if (t2Wr) begin
      txt2_d[addr[3:2]*32 +: 32] = wdata;
    end
    if (wr && addr == `OFS_IRQ_MASK) begin
      mask_d = wdata[1:0];
    end
    if (rd && addr == `OFS_IRQ_STAT) begin
      flag_d = 2'b00;
    end
    case (st_q)
      IDLE: begin
        if (start) begin
          cnt_d = '0;
          // RQ3: operation code picks direction
          dec_d = opsel == `OP_DECRYPT;
          // RQ7: decrypt takes second text, low 64 for DES
          if (opsel == `OP_DECRYPT) begin
            work_d = txt2_q & blkMask;
          end else begin
            work_d = (txt1_q ^ (cmode[0] ? chain_q : '0)) & blkMask;
          end
          // RQ14: expand first on a decrypt with expansion pending, or when asked
          st_d = (opsel == `OP_KEYEXP || (opsel == `OP_DECRYPT && needExp_q)) ? EXPAND : RUN;
          // RQ9: input taken, next block may load
          if (ctrlNow[`BIT_FREE_IE] && opsel != `OP_KEYEXP) begin
            flag_d[1] = 1'b1;
          end
        end
      end
      EXPAND: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == `EXPAND_CYCLES - 5'h01) begin
          cnt_d = '0;
          needExp_d = 1'b0;
          // decrypt goes on to run; a bare expansion ends here
          st_d = dec_q ? RUN : IDLE;
          if (!dec_q) begin
            ctrl_d[`BIT_GO] = 1'b0;
            flag_d[0] = 1'b1;
          end
        end
      end
      RUN: begin
        cnt_d  = cnt_q + 5'h01;
        work_d = stepFn(work_q, keyEff[127:0] ^ keyEff[255:128], isAes, dec_q);
        if (cnt_q == rounds - 5'h01) begin
          st_d = IDLE;
          // RQ8: hardware clears go and flags done
          ctrl_d[`BIT_GO] = 1'b0;
          flag_d[0] = 1'b1;
          // RQ11: result into the opposite text register
          if (dec_q) begin
            txt1_d  = (work_d ^ (cmode[0] ? chain_q : '0)) & blkMask;
            chain_d = work_q;
          end else begin
            txt2_d  = work_d;
            // RQ12: chain kept for next block
            chain_d = work_d;
          end
        end
      end
      default: st_d = IDLE;
    endcase
  end
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q      <= IDLE;
      cnt_q     <= '0;
      work_q    <= '0;
      chain_q   <= '0;
      dec_q     <= 1'b0;
      needExp_q <= 1'b1;
      txt1_q    <= '0;
      txt2_q    <= '0;
      ctrl_q    <= `RST_CTRL;
      cfg_q     <= `RST_CONFIG;
      key_q     <= '0;
      flag_q    <= 2'b00;
      mask_q    <= 2'b00;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      work_q    <= work_d;
      chain_q   <= chain_d;
      dec_q     <= dec_d;
      needExp_q <= needExp_d;
      txt1_q    <= txt1_d;
      txt2_q    <= txt2_d;
      ctrl_q    <= ctrl_d;
      cfg_q     <= cfg_d;
      key_q     <= key_d;
      flag_q    <= flag_d;
      mask_q    <= mask_d;
    end
  end
  // ----------------------------------------------------------------------
  // read port and interrupt
  // ----------------------------------------------------------------------
  // read mux, unmapped reads zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (rd) begin
      case (addr)
        `OFS_CTRL_LOW: rdata_d = {16'h0000, ctrl_q};
        `OFS_CONFIG:   rdata_d = {25'h0000000, cfg_q};
        `OFS_STATUS:   rdata_d = {29'h00000000, needExp_q, st_q != IDLE, fault};
        `OFS_IRQ_STAT: rdata_d = {30'h00000000, flag_q};
        `OFS_IRQ_MASK: rdata_d = {30'h00000000, mask_q};
        default: begin
          if (addr[7:5] == 3'(`OFS_KEY_BASE >> 5)) begin
            rdata_d = key_q[addr[4:2]*32 +: 32];
          end else if (addr[7:4] == 4'(`OFS_TXT1_BASE >> 4)) begin
            rdata_d = txt1_q[addr[3:2]*32 +: 32];
          end else if (addr[7:4] == 4'(`OFS_TXT2_BASE >> 4)) begin
            rdata_d = txt2_q[addr[3:2]*32 +: 32];
          end
        end
      endcase
    end
  end
  // read data register
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
      irq   <= 1'b0;
    end else begin
      rdata <= rdata_d;
      // RQ8: done interrupts only with its enable
      irq   <= (flag_d[0] && mask_d[0] && ctrl_d[`BIT_DONE_IE]) || (flag_d[1] && mask_d[1]);
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence lastRound_s;
    st_q == RUN && cnt_q == rounds - 5'h01;
  endsequence
  sequence decStart_s;
    start && opsel == `OP_DECRYPT;
  endsequence
  go_clear_a: assert property (lastRound_s |=> !ctrl_q[`BIT_GO] && flag_q[0]) // RQ8
    else $error("go not cleared at end of run");
  go_hold_a: assert property (st_q != IDLE |-> ctrl_q[`BIT_GO]) // RQ14
    else $error("go dropped while busy");
  refuse_a: assert property (goWr && fault && st_q == IDLE |=> st_q == IDLE ##1 st_q == IDLE) // RQ5
    else $error("faulty configuration started");
  self_exp_a: assert property (decStart_s and needExp_q |=> st_q == EXPAND [*8] ##1 st_q == RUN) // RQ14
    else $error("decrypt did not expand key first");
  key_mask_a: assert property (klen == 2'b00 |-> keyEff[255:128] == 128'h0 // RQ4
    && (isAes || keyEff[127:64] == 64'h0))
    else $error("key bits above length used");
  des_low_a: assert property (decStart_s and !isAes |=> work_q[127:64] == 64'h0) // RQ7
    else $error("des decrypt took upper text bits");
  free_irq_a: assert property (start && ctrlNow[`BIT_FREE_IE] // RQ9
    && opsel != `OP_KEYEXP |=> flag_q[1])
    else $error("text free flag not raised");
  dir_pick_a: assert property (start |=> dec_q == ($past(opsel) == `OP_DECRYPT)) // RQ3
    else $error("wrong direction latched");
  result_a: assert property (lastRound_s and !dec_q |=> txt2_q == $past(work_d)) // RQ11
    else $error("encrypt result not stored");
endmodule // cipher_engine_ctrl

// *** hdl/cipher_engine_regs.svh ***
// register offsets, field positions, reset values and round counts
// assumes a word-wide register port with byte addresses, one word per control register, eight key words, four per text
`ifndef CIPHER_ENGINE_REGS_SVH
`define CIPHER_ENGINE_REGS_SVH
// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define OFS_CTRL_LOW   8'h00
`define OFS_CONFIG     8'h04
`define OFS_STATUS     8'h08
`define OFS_IRQ_STAT   8'h0C
`define OFS_IRQ_MASK   8'h10
`define OFS_KEY_BASE   8'h20
`define OFS_TXT1_BASE  8'h40
`define OFS_TXT2_BASE  8'h50
// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define BIT_ENABLE     15
`define BIT_KEYPROG    11
`define BIT_FREE_IE    10
`define BIT_DONE_IE    9
`define BIT_GO         8
`define BIT_ALG        0
`define BIT_KEYSRC     6
`define OP_ENCRYPT     4'h0
`define OP_DECRYPT     4'h1
`define OP_KEYEXP      4'h2
// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define RST_CTRL       16'h0000
`define RST_CONFIG     7'h00
`define ROUNDS_DES     5'h10
`define ROUNDS_AES128  5'h0A
`define ROUNDS_AES192  5'h0C
`define ROUNDS_AES256  5'h0E
`define EXPAND_CYCLES  5'h08
`endif

// *** hdl/cipher_engine_pkg.sv ***
// types shared by the cipher engine control block
// assumes the register header is included by the design file
package cipher_engine_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    IDLE,
    EXPAND,
    RUN
  } eng_state_type;
endpackage

// *** tb/tb.sv ***
// ----------------------------------------------------------------------
// self-checking bench for the cipher engine control block
// ----------------------------------------------------------------------
// assumes the register header and package in hdl/, one 50 MHz clock
`timescale 1ns/100ps
`include "cipher_engine_regs.svh"
module tb
  import cipher_engine_pkg::*;
;
  logic         clk;         // system clock
  logic         reset;       // synchronous reset
  logic [7:0]   addr;        // register address
  logic [31:0]  wdata;       // write data
  logic         wr;          // write strobe
  logic         rd;          // read strobe
  logic [31:0]  rdata;       // read data
  logic [255:0] storedKey;   // stored key input
  logic         keyStored;   // key storage pulse
  logic         irq;         // interrupt level
  logic [31:0]  d;           // scratch read value
  logic [31:0]  r0;          // ciphertext word 0
  logic [31:0]  r1;          // ciphertext word 1
  int           mismatches;  // failed compares
  int           numChecks;   // compares made
  int           cycles;      // timeout counter
  int           n;           // measured latency
  // rows: ctrl, config, expected fault bit
  logic [31:0]  rows [9] = '{32'h0000_0001, 32'h8000_0000, 32'h8000_0401,
    32'h8000_3001, 32'h8003_0101, 32'h8002_0001, 32'h8002_0100,
    32'h8001_0300, 32'h8000_6100};
  localparam logic [31:0] P0 = 32'h1357_9BDF;  // plaintext word 0
  localparam logic [31:0] P1 = 32'h2468_ACE0;  // plaintext word 1

  cipher_engine_ctrl i_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .storedKey(storedKey), .keyStored(keyStored), .irq(irq));

  // ----------------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // bus tasks and compare
  // ----------------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // edges from the accepting edge until irq is seen high
  task automatic wait_irq();
    n = 0;
    #1;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // start, time completion by the done interrupt, clear the flag
  task automatic run_op(logic [31:0] c, int e);
    wr_reg(`OFS_CTRL_LOW, c);
    wait_irq();
    chk("op cycles", 1, (n == e || n == e + 1));
    rd_reg(`OFS_IRQ_STAT, d);
    chk("done flag", 32'h0000_0001, d);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    keyStored = 1'b0; storedKey = {8{32'hC3C3_5A5A}};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_reg(`OFS_CTRL_LOW, d);
    chk("ctrl reset", 32'h0, d);
    rd_reg(`OFS_STATUS, d);
    chk("status reset", 32'h0000_0005, d);
    // fault decode over the configuration table
    foreach (rows[i]) begin
      wr_reg(`OFS_CTRL_LOW, {16'h0, rows[i][31:16]});
      wr_reg(`OFS_CONFIG, {24'h0, rows[i][15:8]});
      rd_reg(`OFS_STATUS, d);
      chk("fault bit", {31'h0, rows[i][0]}, d & 32'h1);
    end
    // go refused under an illegal chaining mode
    wr_reg(`OFS_CONFIG, 32'h0000_0004);
    wr_reg(`OFS_CTRL_LOW, 32'h0000_8300);
    rd_reg(`OFS_CTRL_LOW, d);
    chk("go refused", 32'h0000_8200, d);
    // DES encrypt, upper text and key words are junk
    wr_reg(`OFS_IRQ_MASK, 32'h1);
    wr_reg(`OFS_CONFIG, 32'h0);
    wr_reg(`OFS_KEY_BASE, 32'h0123_4567);
    wr_reg(`OFS_KEY_BASE + 8'h04, 32'h89AB_CDEF);
    wr_reg(`OFS_KEY_BASE + 8'h08, 32'hA5A5_0F0F);
    wr_reg(`OFS_TXT1_BASE, P0);
    wr_reg(`OFS_TXT1_BASE + 8'h04, P1);
    wr_reg(`OFS_TXT1_BASE + 8'h08, 32'hFFFF_0000);
    run_op(32'h0000_8300, 16);
    rd_reg(`OFS_TXT2_BASE, r0);
    rd_reg(`OFS_TXT2_BASE + 8'h04, r1);
    rd_reg(`OFS_IRQ_STAT, d);
    chk("flag cleared", 32'h0, d);
    // unused key bits changed, same text restarted
    wr_reg(`OFS_KEY_BASE + 8'h08, 32'h5A5A_F0F0);
    run_op(32'h0000_8300, 16);
    rd_reg(`OFS_TXT2_BASE, d);
    chk("key word0 only", r0, d);
    rd_reg(`OFS_TXT2_BASE + 8'h04, d);
    chk("key word1 only", r1, d);
    // first decrypt expands the key, then restores the plaintext
    wr_reg(`OFS_TXT1_BASE, 32'h0);
    wr_reg(`OFS_TXT1_BASE + 8'h04, 32'h0);
    wr_reg(`OFS_TXT2_BASE + 8'h08, 32'h7777_7777);
    run_op(32'h0000_8301, 24);
    rd_reg(`OFS_TXT1_BASE, d);
    chk("plain word0", P0, d);
    rd_reg(`OFS_TXT1_BASE + 8'h04, d);
    chk("plain word1", P1, d);
    rd_reg(`OFS_STATUS, d);
    chk("expansion done", 32'h0, d & 32'h4);
    run_op(32'h0000_8301, 16);
    // key storage pulse forces a new expansion
    @(posedge clk);
    keyStored <= 1'b1;
    @(posedge clk);
    keyStored <= 1'b0;
    rd_reg(`OFS_STATUS, d);
    chk("expansion pending", 32'h4, d & 32'h4);
    // clearing go while busy is ignored
    wr_reg(`OFS_CTRL_LOW, 32'h0000_8300);
    wr_reg(`OFS_CTRL_LOW, 32'h0000_8200);
    rd_reg(`OFS_CTRL_LOW, d);
    chk("go held", 32'h0000_8300, d);
    wait_irq();
    rd_reg(`OFS_IRQ_STAT, d);
    chk("held go done", 32'h0000_0001, d);
    // text free interrupt right after start
    wr_reg(`OFS_IRQ_MASK, 32'h2);
    wr_reg(`OFS_CTRL_LOW, 32'h0000_8700);
    wait_irq();
    chk("free early", 1, n <= 2);
    rd_reg(`OFS_CTRL_LOW, d);
    chk("go on free irq", 32'h0000_8700, d);
    repeat (20) @(posedge clk);
    rd_reg(`OFS_IRQ_STAT, d);
    chk("both flags", 32'h3, d);
    rd_reg(`OFS_IRQ_STAT, d);
    chk("irq low", 32'h0, {31'h0, irq});
    // AES round counts per key length, then key expansion
    wr_reg(`OFS_IRQ_MASK, 32'h1);
    // stored key source gives the same block as that key typed in
    wr_reg(`OFS_CONFIG, 32'h0000_0040);
    run_op(32'h0000_8300, 16);
    rd_reg(`OFS_TXT2_BASE, r0);
    rd_reg(`OFS_TXT2_BASE + 8'h04, r1);
    wr_reg(`OFS_CONFIG, 32'h0);
    wr_reg(`OFS_KEY_BASE, 32'hC3C3_5A5A);
    wr_reg(`OFS_KEY_BASE + 8'h04, 32'hC3C3_5A5A);
    run_op(32'h0000_8300, 16);
    rd_reg(`OFS_TXT2_BASE, d);
    chk("stored key word0", r0, d);
    rd_reg(`OFS_TXT2_BASE + 8'h04, d);
    chk("stored key word1", r1, d);
    for (int k = 0; k < 3; k++) begin
      wr_reg(`OFS_CONFIG, 32'h1 | (k << 4));
      run_op(32'h0000_8300, 10 + 2 * k);
    end
    run_op(32'h0000_8302, 8);
    // unmapped write leaves control untouched
    wr_reg(8'hF0, 32'hFFFF_FFFF);
    rd_reg(`OFS_CTRL_LOW, d);
    chk("ctrl after unmapped", 32'h0000_8202, d);
    complete_run();
  end
endmodule  // tb
